// *** design/lqta_pkg.sv ***
// Shared constants and types for the link quality threshold access block
package lqta_pkg;

  localparam int METRIC_COUNT = 5;
  localparam int WARN_W = 10;
  localparam int IRQ_W = 2;

  // Register indices; byte address is four times the index
  localparam logic [7:0] QTA_INDEX = 8'h1E;
  localparam logic [7:0] QMC_INDEX = 8'h1D;
  localparam logic [7:0] IRQ_STATUS_INDEX = 8'h20;
  localparam logic [7:0] IRQ_MASK_INDEX = 8'h21;
  localparam logic [7:0] PWR_CTRL_INDEX = 8'h22;
  localparam logic [11:0] QTA_ADDR = {2'h0, QTA_INDEX, 2'h0};
  localparam logic [11:0] QMC_ADDR = {2'h0, QMC_INDEX, 2'h0};
  localparam logic [11:0] IRQ_STATUS_ADDR = {2'h0, IRQ_STATUS_INDEX, 2'h0};
  localparam logic [11:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_INDEX, 2'h0};
  localparam logic [11:0] PWR_CTRL_ADDR = {2'h0, PWR_CTRL_INDEX, 2'h0};

  // Field positions
  localparam int CAPTURE_BIT = 13;
  localparam int STROBE_BIT = 12;
  localparam int SEL_LSB = 9;
  localparam int BOUND_BIT = 8;
  localparam int MON_ON_BIT = 15;
  localparam int PWR_DOWN_BIT = 0;
  localparam int IRQ_WARN_BIT = 0;
  localparam int IRQ_CAPTURE_BIT = 1;

  // Metric select encodings
  localparam logic [2:0] METRIC_EQ = 3'h0;
  localparam logic [2:0] METRIC_GAIN = 3'h1;
  localparam logic [2:0] METRIC_WANDER = 3'h2;
  localparam logic [2:0] METRIC_FREQ_OFF = 3'h3;
  localparam logic [2:0] METRIC_FREQ_CTL = 3'h4;

  // Reset values
  localparam logic [12:0] ACCESS_RESET = 13'h0000;
  localparam logic [7:0] THR_LO_RESET = 8'h00;
  localparam logic [7:0] THR_HI_RESET = 8'hFF;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  typedef struct packed {
    logic capture;
    logic [2:0] metric;
    logic bound;
    logic [7:0] value;
  } lqta_access_type;

  typedef logic [METRIC_COUNT-1:0][7:0] lqta_bytes_type;

  typedef struct packed {
    lqta_bytes_type level;
  } lqta_levels_type;

  function automatic logic lqta_sel_ok(input logic [2:0] sel);
    return sel <= METRIC_FREQ_CTL;
  endfunction

  function automatic logic [7:0] lqta_pick(input lqta_bytes_type b, input logic [2:0] sel);
    logic [7:0] r;
    r = 8'h00;
    for (int m = 0; m < METRIC_COUNT; m++) begin
      if (sel == 3'(m)) begin
        r = b[m];
      end
    end
    return r;
  endfunction

endpackage

// *** design/lqta_monitor.sv ***
// Threshold comparison producing one-cycle warning pulses
`timescale 1ns/1ps
module lqta_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic active,
  input lqta_pkg::lqta_levels_type levels,
  input lqta_pkg::lqta_bytes_type thr_lo,
  input lqta_pkg::lqta_bytes_type thr_hi,
  // Events
  output logic [lqta_pkg::WARN_W-1:0] warn_raise
);

  logic [lqta_pkg::WARN_W-1:0] violation;
  logic [lqta_pkg::WARN_W-1:0] prev;

  // Even bit low bound, odd bit high bound, as in the warning field
  always_comb begin
    violation = '0;
    for (int m = 0; m < lqta_pkg::METRIC_COUNT; m++) begin
      violation[2*m] = active && (levels.level[m] < thr_lo[m]);
      violation[2*m+1] = active && (levels.level[m] > thr_hi[m]);
    end
  end

  // Edge only, so a standing violation warns once, not again until it ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= '0;
    end else begin
      prev <= violation;
    end
  end

  assign warn_raise = violation & ~prev;

endmodule // lqta_monitor

// *** design/lqta_top.sv ***
// APB register bank for link quality thresholds, sampling and warnings
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
//
// What this block does
// - Bits 15:14 ignore writes, read zero
// - Capture bit samples the selected parameter
// - Strobe writes value byte into selected threshold
// - Strobe bit always reads back zero
// - Metric select picks one of five parameters
// - Bound bit picks low or high threshold
// - Capture clear: written byte is threshold data
// - Capture clear: read returns selected threshold
// - Capture set: read returns sampled parameter
// - Sampled value frozen until next capture
// - No threshold writes during power-down
// - Writable fields reset to zero, except high thresholds, which reset to FF
// - Monitor runs only when enabled with link
// - Crossing sets warning bit and interrupt
// - Reading monitor control clears warnings
module lqta_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver parameters and link state
  input lqta_pkg::lqta_levels_type rx_level,
  input wire logic link_100_ok,
  // Interrupt
  output logic irq
);

  lqta_pkg::lqta_access_type access;
  lqta_pkg::lqta_bytes_type thr_lo;
  lqta_pkg::lqta_bytes_type thr_hi;
  logic [7:0] sample_value;
  logic monitor_on;
  logic power_down;
  logic [lqta_pkg::WARN_W-1:0] warn;
  logic [lqta_pkg::WARN_W-1:0] warn_snap;
  logic [lqta_pkg::WARN_W-1:0] warn_raise;
  logic [lqta_pkg::IRQ_W-1:0] irq_status;
  logic [lqta_pkg::IRQ_W-1:0] irq_mask;
  logic [lqta_pkg::IRQ_W-1:0] irq_event;

  logic setup;
  logic wr;
  logic rd;
  logic hit;
  logic [31:0] next_prdata;
  logic next_err;
  logic wr_qta;
  logic rd_qmc;
  logic monitor_active;
  lqta_pkg::lqta_access_type wr_access;
  logic thr_wr_hit;
  logic capture_start;
  logic [7:0] picked_level;
  logic [7:0] qta_value;

  // Zero wait states; read data is latched during setup
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  always_comb begin
    case (paddr)
      lqta_pkg::QTA_ADDR: hit = 1'b1;
      lqta_pkg::QMC_ADDR: hit = 1'b1;
      lqta_pkg::IRQ_STATUS_ADDR: hit = 1'b1;
      lqta_pkg::IRQ_MASK_ADDR: hit = 1'b1;
      lqta_pkg::PWR_CTRL_ADDR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign wr_qta = wr && (paddr == lqta_pkg::QTA_ADDR);
  assign rd_qmc = rd && (paddr == lqta_pkg::QMC_ADDR);
  // Strobe sits between capture and select, so it is skipped, never stored
  assign wr_access = {pwdata[lqta_pkg::CAPTURE_BIT], pwdata[lqta_pkg::SEL_LSB +: 3],
    pwdata[lqta_pkg::BOUND_BIT], pwdata[7:0]};

  // Threshold store needs strobe, a used code and power up
  assign thr_wr_hit = wr_qta && pwdata[lqta_pkg::STROBE_BIT]
    && lqta_pkg::lqta_sel_ok(wr_access.metric) && !power_down;
  assign capture_start = wr_qta && wr_access.capture;
  assign picked_level = lqta_pkg::lqta_pick(rx_level.level, wr_access.metric);

  // Value byte seen by a read of the access register
  always_comb begin
    qta_value = 8'h00;
    if (access.capture) begin
      qta_value = sample_value;
    end else if (lqta_pkg::lqta_sel_ok(access.metric)) begin
      qta_value = access.bound ? lqta_pkg::lqta_pick(thr_hi, access.metric)
        : lqta_pkg::lqta_pick(thr_lo, access.metric);
    end
  end

  always_comb begin
    next_prdata = lqta_pkg::RDATA_IDLE;
    case (paddr)
      lqta_pkg::QTA_ADDR: begin
        // Strobe and top two bits are never stored, so they read zero
        next_prdata[lqta_pkg::CAPTURE_BIT] = access.capture;
        next_prdata[lqta_pkg::SEL_LSB +: 3] = access.metric;
        next_prdata[lqta_pkg::BOUND_BIT] = access.bound;
        next_prdata[7:0] = qta_value;
      end
      lqta_pkg::QMC_ADDR: begin
        next_prdata[lqta_pkg::MON_ON_BIT] = monitor_on;
        next_prdata[lqta_pkg::WARN_W-1:0] = warn;
      end
      lqta_pkg::IRQ_STATUS_ADDR: next_prdata[lqta_pkg::IRQ_W-1:0] = irq_status;
      lqta_pkg::IRQ_MASK_ADDR: next_prdata[lqta_pkg::IRQ_W-1:0] = irq_mask;
      lqta_pkg::PWR_CTRL_ADDR: next_prdata[lqta_pkg::PWR_DOWN_BIT] = power_down;
      default: next_prdata = lqta_pkg::RDATA_IDLE;
    endcase
  end

  assign next_err = !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= lqta_pkg::RDATA_IDLE;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? lqta_pkg::RDATA_IDLE : next_prdata;
      pslverr <= next_err;
    end
  end

  // Snapshot of reported warnings; only those are cleared by the read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_snap <= '0;
    end else if (setup && !pwrite && paddr == lqta_pkg::QMC_ADDR) begin
      warn_snap <= warn;
    end
  end

  // Access register fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access <= lqta_pkg::ACCESS_RESET;
    end else if (wr_qta) begin
      access <= wr_access;
    end
  end

  // Threshold storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int m = 0; m < lqta_pkg::METRIC_COUNT; m++) begin
        thr_lo[m] <= lqta_pkg::THR_LO_RESET;
        thr_hi[m] <= lqta_pkg::THR_HI_RESET;
      end
    end else if (thr_wr_hit) begin
      for (int m = 0; m < lqta_pkg::METRIC_COUNT; m++) begin
        if (wr_access.metric == 3'(m)) begin
          if (wr_access.bound) begin
            thr_hi[m] <= wr_access.value;
          end else begin
            thr_lo[m] <= wr_access.value;
          end
        end
      end
    end
  end

  // Sample holds until software starts another capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_value <= 8'h00;
    end else if (capture_start) begin
      sample_value <= picked_level;
    end
  end

  // Monitor control and power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_on <= 1'b0;
      power_down <= 1'b0;
    end else if (wr) begin
      if (paddr == lqta_pkg::QMC_ADDR) begin
        monitor_on <= pwdata[lqta_pkg::MON_ON_BIT];
      end
      if (paddr == lqta_pkg::PWR_CTRL_ADDR) begin
        power_down <= pwdata[lqta_pkg::PWR_DOWN_BIT];
      end
    end
  end

  assign monitor_active = monitor_on && link_100_ok;

  lqta_monitor u_monitor (
    .pclk(pclk),
    .presetn(presetn),
    .active(monitor_active),
    .levels(rx_level),
    .thr_lo(thr_lo),
    .thr_hi(thr_hi),
    .warn_raise(warn_raise)
  );

  // Warnings clear on read; a new crossing in that cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn <= '0;
    end else begin
      warn <= (warn & ~(rd_qmc ? warn_snap : '0)) | warn_raise;
    end
  end

  assign irq_event[lqta_pkg::IRQ_WARN_BIT] = |warn_raise;
  assign irq_event[lqta_pkg::IRQ_CAPTURE_BIT] = capture_start;

  // Write one to clear; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status
        & ~((wr && paddr == lqta_pkg::IRQ_STATUS_ADDR) ? pwdata[lqta_pkg::IRQ_W-1:0] : '0))
        | irq_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= '0;
    end else if (wr && paddr == lqta_pkg::IRQ_MASK_ADDR) begin
      irq_mask <= pwdata[lqta_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rd_qta;
  assign rd_qta = rd && (paddr == lqta_pkg::QTA_ADDR);

  AST_RESERVED_ZERO: assert property (
    rd_qta |-> prdata[15:14] == 2'h0)
    else $error("reserved bits read nonzero");

  AST_STROBE_READS_ZERO: assert property (
    wr_qta ##1 (psel && !penable) ##1 rd_qta |-> !prdata[lqta_pkg::STROBE_BIT])
    else $error("strobe bit read back as one");

  AST_CAPTURE_SAMPLE: assert property (
    capture_start |=> sample_value == $past(picked_level))
    else $error("capture did not load the parameter");

  AST_METRIC_MAP: assert property (
    capture_start && wr_access.metric == lqta_pkg::METRIC_FREQ_CTL
    |=> sample_value == $past(rx_level.level[4]))
    else $error("metric select mapped wrongly");

  AST_THR_WRITE: assert property (
    thr_wr_hit |=> ($past(wr_access.bound) ?
      lqta_pkg::lqta_pick(thr_hi, $past(wr_access.metric)) :
      lqta_pkg::lqta_pick(thr_lo, $past(wr_access.metric))) == $past(wr_access.value))
    else $error("threshold not stored");

  AST_PD_BLOCKS: assert property (
    wr_qta && pwdata[lqta_pkg::STROBE_BIT] && power_down
    |=> $stable(thr_lo) && $stable(thr_hi))
    else $error("threshold changed in power-down");

  AST_SAMPLE_FROZEN: assert property (
    !capture_start |=> $stable(sample_value))
    else $error("sample changed without capture");

  AST_READ_SAMPLE: assert property (
    rd_qta && access.capture |-> prdata[7:0] == sample_value)
    else $error("capture read did not return sample");

  AST_READ_THR: assert property (
    rd_qta && !access.capture && access.metric == lqta_pkg::METRIC_EQ && access.bound
    |-> prdata[7:0] == thr_hi[0])
    else $error("threshold read wrong");

  AST_UNUSED_SEL: assert property (
    rd_qta && !access.capture && !lqta_pkg::lqta_sel_ok(access.metric)
    |-> prdata[7:0] == 8'h00)
    else $error("unused metric read nonzero");

  AST_RESET_ZERO: assert property (
    $rose(presetn) |-> access == lqta_pkg::ACCESS_RESET)
    else $error("access fields not zero after reset");

  AST_MONITOR_GATE: assert property (
    !monitor_active ##1 !monitor_active |-> warn_raise == '0)
    else $error("warning while monitor off");

  AST_WARN_SET: assert property (
    |warn_raise |=> ((warn & $past(warn_raise)) == $past(warn_raise))
      && irq_status[lqta_pkg::IRQ_WARN_BIT])
    else $error("crossing not flagged");

  AST_READ_CLEARS: assert property (
    rd_qmc && warn_raise == '0 |=> (warn & $past(warn_snap)) == '0)
    else $error("read did not clear warnings");

  AST_FIELDS_STORED: assert property (
    wr_qta |=> access.capture == $past(pwdata[lqta_pkg::CAPTURE_BIT])
      && access.metric == $past(pwdata[lqta_pkg::SEL_LSB +: 3])
      && access.bound == $past(pwdata[lqta_pkg::BOUND_BIT])
      && access.value == $past(pwdata[7:0]))
    else $error("access fields not stored as written");

  AST_UNUSED_DISCARD: assert property (
    wr_qta && pwdata[lqta_pkg::STROBE_BIT] && !lqta_pkg::lqta_sel_ok(wr_access.metric)
    |=> $stable(thr_lo) && $stable(thr_hi))
    else $error("unused metric changed a threshold");

  AST_READ_LOW: assert property (
    rd_qta && !access.capture && access.metric == lqta_pkg::METRIC_GAIN && !access.bound
    |-> prdata[7:0] == thr_lo[1])
    else $error("low threshold read wrong");

  AST_LINK_GATE: assert property (
    !link_100_ok || !monitor_on |-> warn_raise == '0)
    else $error("warning raised without link or enable");

  AST_WARN_ONLY_RAISED: assert property (
    warn_raise == '0 |=> (warn & ~$past(warn)) == '0)
    else $error("warning bit set without a crossing");

  COV_THR_WRITE: cover property (thr_wr_hit ##2 rd_qta);
  COV_CAPTURE: cover property (capture_start ##2 rd_qta);
  COV_WARN_CLEAR: cover property (|warn ##[1:20] rd_qmc);
  COV_IRQ: cover property ($rose(irq));
  COV_PD_WRITE: cover property (wr_qta && pwdata[lqta_pkg::STROBE_BIT] && power_down);

endmodule // lqta_top

// *** verif/lqta_tb_top.sv ***
// Self-checking bench for the link quality threshold access block
`timescale 1ns/1ps
module lqta_tb_top;
  localparam logic [11:0] A_QTA = lqta_pkg::QTA_ADDR;
  localparam logic [11:0] A_QMC = lqta_pkg::QMC_ADDR;
  localparam logic [11:0] A_STAT = lqta_pkg::IRQ_STATUS_ADDR;
  localparam logic [11:0] A_MASK = lqta_pkg::IRQ_MASK_ADDR;
  localparam logic [11:0] A_PWR = lqta_pkg::PWR_CTRL_ADDR;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  lqta_pkg::lqta_levels_type rx_level = {5{8'h40}};
  logic link_100_ok = 1'b0;
  logic irq;
  int err_count = 0;
  int checks_done = 0;

  always #2 pclk = ~pclk;

  lqta_top u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rx_level(rx_level),
    .link_100_ok(link_100_ok),
    .irq(irq)
  );

  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One edge passes first so psel is never lowered and raised in one step
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) begin
      err_count++;
      stop_test();
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    logic [31:0] x;
    logic e;
    apb(1'b1, addr, data, x, e);
    check1("write pslverr", 1'b0, e);
  endtask

  task automatic rdchk(input string what, input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] x;
    logic e;
    apb(1'b0, addr, 32'h0000_0000, x, e);
    check32(what, exp, x);
    check1("read pslverr", 1'b0, e);
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    logic [31:0] sel;
    logic [31:0] x;
    logic e;
    logic [7:0] v;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("access reset", A_QTA, 32'h0000_0000);
    for (int m = 0; m < 5; m++) begin
      for (int b = 0; b < 2; b++) begin
        sel = 32'(m * 512 + b * 256);
        v = (b == 1) ? 8'(240 - m) : 8'(16 + m);
        wr(A_QTA, sel);
        rdchk("threshold reset", A_QTA, sel | ((b == 1) ? 32'h0000_00FF : 32'h0));
        wr(A_QTA, 32'h0000_D000 | sel | 32'(v));
        rdchk("threshold written", A_QTA, sel | 32'(v));
      end
    end
    // Second pass catches writes that landed in the wrong slot
    for (int m = 0; m < 5; m++) begin
      for (int b = 0; b < 2; b++) begin
        sel = 32'(m * 512 + b * 256);
        v = (b == 1) ? 8'(240 - m) : 8'(16 + m);
        wr(A_QTA, sel);
        rdchk("threshold kept", A_QTA, sel | 32'(v));
      end
    end
    for (int m = 5; m < 8; m++) begin
      wr(A_QTA, 32'h0000_105A | 32'(m * 512));
      rdchk("unused metric", A_QTA, 32'(m * 512));
    end
    wr(A_PWR, 32'h0000_0001);
    rdchk("power ctrl", A_PWR, 32'h0000_0001);
    wr(A_QTA, 32'h0000_1077);
    wr(A_PWR, 32'h0000_0000);
    wr(A_QTA, 32'h0000_0000);
    rdchk("power down write", A_QTA, 32'h0000_0010);
    rx_level.level[2] <= 8'h3C;
    wr(A_QTA, 32'h0000_2400);
    rx_level.level[2] <= 8'hC3;
    settle();
    rdchk("sample frozen", A_QTA, 32'h0000_243C);
    rx_level.level[4] <= 8'h99;
    wr(A_QTA, 32'h0000_2800);
    rdchk("sample refresh", A_QTA, 32'h0000_2899);
    check1("irq masked", 1'b0, irq);
    rdchk("capture status", A_STAT, 32'h0000_0002);
    wr(A_MASK, 32'h0000_0002);
    @(posedge pclk);
    check1("irq unmasked", 1'b1, irq);
    wr(A_STAT, 32'h0000_0002);
    @(posedge pclk);
    check1("irq cleared", 1'b0, irq);
    rdchk("status cleared", A_STAT, 32'h0000_0000);
    wr(A_QTA, 32'h0000_0000);
    rx_level.level[2] <= 8'h40;
    rx_level.level[4] <= 8'h40;
    wr(A_QMC, 32'h0000_8000);
    rx_level.level[1] <= 8'h05;
    settle();
    rdchk("no link no warn", A_QMC, 32'h0000_8000);
    rx_level.level[1] <= 8'h40;
    link_100_ok <= 1'b1;
    settle();
    rx_level.level[1] <= 8'h05;
    settle();
    rdchk("gain low warn", A_QMC, 32'h0000_8004);
    rdchk("warn clear on read", A_QMC, 32'h0000_8000);
    rx_level.level[3] <= 8'hFF;
    settle();
    rdchk("offset high warn", A_QMC, 32'h0000_8080);
    rdchk("warn status", A_STAT, 32'h0000_0001);
    wr(A_MASK, 32'h0000_0001);
    @(posedge pclk);
    check1("warn irq", 1'b1, irq);
    rdchk("irq mask", A_MASK, 32'h0000_0001);
    apb(1'b0, 12'hFFC, 32'h0000_0000, x, e);
    check32("unmapped read data", 32'h0000_0000, x);
    check1("unmapped read error", 1'b1, e);
    apb(1'b1, 12'hFFC, 32'hFFFF_FFFF, x, e);
    check1("unmapped write error", 1'b1, e);
    stop_test();
  end
endmodule // lqta_tb_top
